// ==== verilog/sfts_pkg.sv ====
package sfts_pkg;

  // ****************************************
  // timing and geometry defaults
  // ****************************************
  localparam int unsigned SLAVE_EXTRA_CLKS = 16;
  localparam int unsigned SYNC_STAGES = 2;
  localparam logic [15:0] DEF_FRAME_LINES = 16'h0020;
  localparam logic [15:0] DEF_LINE_PCK = 16'h0010;
  localparam logic [15:0] DEF_VBLANK_ROWS = 16'h0010;
  localparam logic [15:0] DEF_ACTIVE_PCK = 16'h0008;
  localparam logic [15:0] DEF_EXTRA_DELAY = 16'h0000;
  localparam logic [15:0] DEF_INTEG_ROWS = 16'h0008;

  // ****************************************
  // sync codes and protocols
  // ****************************************
  typedef enum logic [1:0] {
    SFTS_PROTO_PARALLEL = 2'h0,
    SFTS_PROTO_STREAM_S = 2'h1,
    SFTS_PROTO_STREAM_SP = 2'h2,
    SFTS_PROTO_PACKET = 2'h3
  } sfts_proto_t;

  typedef struct packed {
    logic blank_row_start_code;
    logic frame_start_code;
    logic line_start_code;
    logic line_end_code;
    logic frame_end_code;
  } sfts_codes_t;

  // frame timing settings, shadowed twice before use
  typedef struct packed {
    logic [15:0] frame_lines;
    logic [15:0] line_pck;
    logic [15:0] vblank_rows;
    logic [15:0] active_pck;
    logic [15:0] extra_delay;
    logic [15:0] integ_rows;
  } sfts_cfg_t;

  localparam sfts_cfg_t CFG_RESET = '{DEF_FRAME_LINES, DEF_LINE_PCK,
    DEF_VBLANK_ROWS, DEF_ACTIVE_PCK, DEF_EXTRA_DELAY, DEF_INTEG_ROWS};

endpackage : sfts_pkg

// ==== verilog/sfts_frame_trigger.sv ====
// Overview of operation
// - slave mode starts frames only on a rising trigger edge while armed.
// - after accepting, stay disarmed one frame plus 16 clocks.
// - edges arriving while disarmed are dropped without starting a frame.
// - without slave mode, frames restart once extra delay expires.
// - while armed and waiting, shutter and read pointers halt.
// - blanking rows come first, then active rows; frame is lines times row.
// - parallel output marks frame and line by valid signals only.
// - serial sync codes depend on the chosen protocol variant.
// - settings written in frame n apply from frame n+2.
// - wait lengthens integration only of rows reset since last pulse.
// - free-run period is lines times row clocks plus extra delay.
`timescale 1ns/1ps
`default_nettype none
module sfts_frame_trigger (
  // clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  // control
  input wire logic STREAM_EN_I,
  input wire logic SLAVE_EN_I,
  input wire logic TRIG_EN_I,
  input wire sfts_pkg::sfts_proto_t PROTO_I,
  input wire logic CFG_WR_I,
  input wire sfts_pkg::sfts_cfg_t CFG_I,
  // trigger input
  input wire logic FRAME_SYNC_PULSE_I,
  // frame status
  output logic ARMED_O,
  output logic WAITING_O,
  output logic FRAME_START_O,
  output logic [15:0] READ_ROW_O,
  output logic [15:0] SHUTTER_ROW_O,
  output logic ROW_STEP_O,
  output logic SHUTTER_STEP_O,
  // output framing
  output logic FRAME_VALID_O,
  output logic LINE_VALID_O,
  output sfts_pkg::sfts_codes_t CODES_O
);
  default clocking cb_sys @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // ****************************************
  // trigger synchroniser
  // ****************************************
  logic [sfts_pkg::SYNC_STAGES-1:0] sync_q;
  logic trig_prev;
  logic trig_rise;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      sync_q <= '0;
      trig_prev <= 1'b0;
    end else begin
      sync_q <= {sync_q[sfts_pkg::SYNC_STAGES-2:0],
        FRAME_SYNC_PULSE_I & TRIG_EN_I};
      trig_prev <= sync_q[sfts_pkg::SYNC_STAGES-1];
    end
  end
  assign trig_rise = sync_q[sfts_pkg::SYNC_STAGES-1] & ~trig_prev;

  // ****************************************
  // settings shadow
  // ****************************************
  sfts_pkg::sfts_cfg_t cfg_pend;
  sfts_pkg::sfts_cfg_t cfg_next;
  sfts_pkg::sfts_cfg_t cfg_act;
  logic pend_vld;
  logic next_vld;
  logic frame_start;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      cfg_pend <= sfts_pkg::CFG_RESET;
      cfg_next <= sfts_pkg::CFG_RESET;
      cfg_act <= sfts_pkg::CFG_RESET;
      pend_vld <= 1'b0;
      next_vld <= 1'b0;
    end else begin
      if (frame_start) begin
        next_vld <= pend_vld;
        pend_vld <= CFG_WR_I;
        if (next_vld)
          cfg_act <= cfg_next;
        if (pend_vld)
          cfg_next <= cfg_pend;
      end else if (CFG_WR_I) begin
        pend_vld <= 1'b1;
      end
      if (CFG_WR_I)
        cfg_pend <= CFG_I;
    end
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  typedef enum logic [1:0] {
    SFTS_IDLE = 2'b00,
    SFTS_READ = 2'b01,
    SFTS_DELAY = 2'b10,
    SFTS_WAIT = 2'b11
  } sfts_state_t;
  sfts_state_t state;
  logic [15:0] col_cnt;
  logic [15:0] row_cnt;
  logic [15:0] dly_cnt;
  logic row_end;
  logic last_row;
  logic dly_done;
  logic start_ok;
  logic no_delay;
  assign row_end = (col_cnt == cfg_act.line_pck - 16'h0001);
  assign last_row = (row_cnt == cfg_act.frame_lines - 16'h0001);
  assign dly_done = (dly_cnt == 16'h0000);
  // edges in other states are dropped
  assign start_ok = (state == SFTS_WAIT) && trig_rise;
  assign no_delay = (cfg_act.extra_delay == 16'h0000);
  assign frame_start = STREAM_EN_I && (start_ok || (!SLAVE_EN_I &&
    ((state == SFTS_IDLE) || (state == SFTS_WAIT) ||
     ((state == SFTS_DELAY) && dly_done) ||
     ((state == SFTS_READ) && row_end && last_row && no_delay))));

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      state <= SFTS_IDLE;
      dly_cnt <= 16'h0000;
    end else if (!STREAM_EN_I) begin
      state <= SFTS_IDLE;
      dly_cnt <= 16'h0000;
    end else begin
      case (state)
        SFTS_IDLE: begin
          if (SLAVE_EN_I)
            state <= SFTS_WAIT;
          else
            state <= SFTS_READ;
        end
        SFTS_READ: begin
          if (row_end && last_row && SLAVE_EN_I) begin
            state <= SFTS_DELAY;
            dly_cnt <= 16'(sfts_pkg::SLAVE_EXTRA_CLKS - 1);
          end else if (row_end && last_row && !no_delay) begin
            // zero delay restarts straight from the last row, no idle clock
            state <= SFTS_DELAY;
            dly_cnt <= cfg_act.extra_delay - 16'h0001;
          end
        end
        SFTS_DELAY: begin
          // frame plus 16 clocks before rearm
          if (dly_done)
            state <= SLAVE_EN_I ? SFTS_WAIT : SFTS_READ;
          else
            dly_cnt <= dly_cnt - 16'h0001;
        end
        SFTS_WAIT: begin
          if (!SLAVE_EN_I || start_ok)
            state <= SFTS_READ;
        end
        default: state <= SFTS_IDLE;
      endcase
    end
  end

  // ****************************************
  // row pointers
  // ****************************************
  logic running;
  assign running = (state == SFTS_READ);
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || frame_start || !running) begin
      col_cnt <= 16'h0000;
    end else if (row_end) begin
      col_cnt <= 16'h0000;
    end else begin
      col_cnt <= col_cnt + 16'h0001;
    end
  end
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || frame_start) begin
      row_cnt <= 16'h0000;
    end else if (running && row_end && !last_row) begin
      row_cnt <= row_cnt + 16'h0001;
    end
  end

  // shutter leads reads by the integration rows, wrapping in the frame;
  // it freezes with the read pointer, so only rows already reset see the
  // extra wait time
  logic [16:0] shut_sum;
  assign shut_sum = {1'b0, row_cnt} + {1'b0, cfg_act.integ_rows};
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      SHUTTER_ROW_O <= 16'h0000;
    end else if (running) begin
      if (shut_sum >= {1'b0, cfg_act.frame_lines})
        SHUTTER_ROW_O <= 16'(shut_sum - {1'b0, cfg_act.frame_lines});
      else
        SHUTTER_ROW_O <= shut_sum[15:0];
    end
  end

  // ****************************************
  // outputs and sync codes
  // ****************************************
  logic active_row;
  logic active_col;
  assign active_row = running && (row_cnt >= cfg_act.vblank_rows);
  assign active_col = (col_cnt < cfg_act.active_pck);

  function automatic sfts_pkg::sfts_codes_t code_mask(
      input sfts_pkg::sfts_proto_t p);
    case (p)
      sfts_pkg::SFTS_PROTO_STREAM_S: code_mask = 5'h14;
      sfts_pkg::SFTS_PROTO_STREAM_SP: code_mask = 5'h1c;
      sfts_pkg::SFTS_PROTO_PACKET: code_mask = 5'h0f;
      default: code_mask = 5'h00;
    endcase
  endfunction

  sfts_pkg::sfts_codes_t ev;
  always_comb begin
    ev.blank_row_start_code = running && col_cnt == 16'h0000 && !active_row;
    ev.frame_start_code = running && col_cnt == 16'h0000 &&
      row_cnt == cfg_act.vblank_rows;
    ev.line_start_code = active_row && col_cnt == 16'h0000;
    ev.line_end_code = active_row && col_cnt == cfg_act.active_pck;
    ev.frame_end_code = active_row && last_row &&
      col_cnt == cfg_act.active_pck;
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      FRAME_VALID_O <= 1'b0;
      LINE_VALID_O <= 1'b0;
      CODES_O <= '0;
      FRAME_START_O <= 1'b0;
      ROW_STEP_O <= 1'b0;
    end else begin
      FRAME_VALID_O <= active_row;
      LINE_VALID_O <= active_row && active_col;
      CODES_O <= ev & code_mask(PROTO_I);
      FRAME_START_O <= frame_start;
      ROW_STEP_O <= running && row_end;
    end
  end
  assign SHUTTER_STEP_O = ROW_STEP_O;
  assign READ_ROW_O = row_cnt;
  assign ARMED_O = (state == SFTS_WAIT);
  assign WAITING_O = (state == SFTS_WAIT);

  // ****************************************
  // checks
  // ****************************************
  sequence armed_edge_s;
    state == SFTS_WAIT && trig_rise && STREAM_EN_I;
  endsequence
  sequence delay8_s;
    (state == SFTS_DELAY) [*8];
  endsequence
  edge_start_a: assert property (
    armed_edge_s |=> state == SFTS_READ && row_cnt == 16'h0000)
    else $error("armed edge did not start readout");
  disarm_drop_a: assert property (
    (SLAVE_EN_I && trig_rise && state != SFTS_WAIT) |=> !FRAME_START_O)
    else $error("edge accepted while disarmed");
  rearm_delay_a: assert property (
    (state == SFTS_READ && row_end && last_row && SLAVE_EN_I &&
    STREAM_EN_I) |=> delay8_s ##1 delay8_s ##1 state == SFTS_WAIT)
    else $error("rearm timing wrong");
  ptr_halt_a: assert property (
    (state == SFTS_WAIT && !frame_start) |=>
    $stable(row_cnt) && $stable(SHUTTER_ROW_O))
    else $error("pointer moved while waiting");
  free_run_a: assert property (
    (state == SFTS_DELAY && dly_done && !SLAVE_EN_I && STREAM_EN_I) |=>
    FRAME_START_O && state == SFTS_READ && row_cnt == 16'h0000)
    else $error("free-run frame not started");
  zero_delay_a: assert property (
    (state == SFTS_READ && row_end && last_row && !SLAVE_EN_I &&
    STREAM_EN_I && no_delay) |=> FRAME_START_O && state == SFTS_READ)
    else $error("extra clock between frames");
  line_in_frame_a: assert property (
    LINE_VALID_O |-> FRAME_VALID_O)
    else $error("line valid outside frame");
  pkt_codes_a: assert property (
    $past(PROTO_I) == sfts_pkg::SFTS_PROTO_PACKET |->
    !CODES_O.blank_row_start_code)
    else $error("blank row code in packet mode");
  cfg_delay_a: assert property (
    (CFG_WR_I && !frame_start) |=> $stable(cfg_act))
    else $error("setting applied too early");

endmodule : sfts_frame_trigger
`default_nettype wire

// ==== tb/sfts_sync_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// external controller making sync pulses
// ****************************************
module sfts_sync_source (
  // clock
  input wire logic clk_i,
  // request from the bench
  input wire logic fire_i,
  input wire logic [3:0] width_i,
  // pulse to the sensor
  output logic pulse_o
);
  logic [3:0] left = 4'h0;
  always @(posedge clk_i) begin
    if (fire_i && left == 4'h0) begin
      left <= (width_i < 4'h3) ? 4'h3 : width_i;
    end else if (left != 4'h0) begin
      left <= left - 4'h1;
    end
  end
  initial pulse_o = 1'b0;
  always @(negedge clk_i) begin
    pulse_o <= (left != 4'h0);
  end
endmodule : sfts_sync_source
`default_nettype wire

// ==== tb/slave_frame_trigger_sync_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module slave_frame_trigger_sync_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic stream_en = 1'b0;
  logic slave_en = 1'b0;
  logic trig_en = 1'b0;
  logic cfg_wr = 1'b0;
  logic fire = 1'b0;
  logic sync_pulse;
  sfts_pkg::sfts_proto_t proto = sfts_pkg::SFTS_PROTO_PARALLEL;
  sfts_pkg::sfts_cfg_t cfg = sfts_pkg::CFG_RESET;
  logic armed, waiting, fstart, rstep, sstep, fvalid, lvalid;
  logic [15:0] rrow, srow;
  sfts_pkg::sfts_codes_t codes;
  int n_errors = 0;
  int check_count = 0;
  localparam int FRAME_CLKS = int'(sfts_pkg::DEF_FRAME_LINES) *
    int'(sfts_pkg::DEF_LINE_PCK);
  localparam int FREE_CLKS = FRAME_CLKS + int'(sfts_pkg::DEF_EXTRA_DELAY);
  localparam int DISARM_CLKS = FRAME_CLKS +
    int'(sfts_pkg::SLAVE_EXTRA_CLKS);
  localparam int SHUT_HOLD = (int'(sfts_pkg::DEF_FRAME_LINES) - 1 +
    int'(sfts_pkg::DEF_INTEG_ROWS)) % int'(sfts_pkg::DEF_FRAME_LINES);
  always #12.5 clk = ~clk;
  sfts_sync_source partner (.clk_i(clk), .fire_i(fire), .width_i(4'h4),
    .pulse_o(sync_pulse));
  sfts_frame_trigger dut (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .STREAM_EN_I(stream_en), .SLAVE_EN_I(slave_en), .TRIG_EN_I(trig_en),
    .PROTO_I(proto), .CFG_WR_I(cfg_wr), .CFG_I(cfg),
    .FRAME_SYNC_PULSE_I(sync_pulse), .ARMED_O(armed), .WAITING_O(waiting),
    .FRAME_START_O(fstart), .READ_ROW_O(rrow), .SHUTTER_ROW_O(srow),
    .ROW_STEP_O(rstep), .SHUTTER_STEP_O(sstep), .FRAME_VALID_O(fvalid),
    .LINE_VALID_O(lvalid), .CODES_O(codes));
  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // bounded so a dead trigger path cannot hang the run
  task automatic wait_start(output int w);
    w = 0;
    do begin
      @(negedge clk);
      w++;
    end while (fstart !== 1'b1 && w < 3000);
  endtask : wait_start
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_slave;
    int w, c, starts, rows, ssteps, first_lv;
    logic [15:0] r0, s0;
    slave_en = 1'b1;
    tick(1);
    trig_en = 1'b1;
    tick(1);
    stream_en = 1'b1;
    tick(6);
    check(armed, 1'b1, "not armed in slave mode");
    check(waiting, 1'b1, "not waiting for pulse");
    r0 = rrow;
    s0 = srow;
    tick(20);
    check(rrow, r0, "read row moved while waiting");
    check(srow, s0, "shutter row moved while waiting");
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    wait_start(w);
    check(w <= 6, 1'b1, "frame start late after edge");
    c = 0;
    starts = 0;
    rows = 0;
    ssteps = 0;
    first_lv = -1;
    while (armed !== 1'b1 && c < 1000) begin
      @(negedge clk);
      c++;
      fire = (c == 100);
      starts += fstart;
      rows += rstep;
      ssteps += sstep;
      if (lvalid === 1'b1 && first_lv < 0) first_lv = c;
    end
    check(c, DISARM_CLKS, "disarm span wrong");
    check(starts, 0, "edge taken while disarmed");
    check(rows, 32, "row count per frame");
    check(ssteps, 32, "shutter row steps");
    check(rrow, sfts_pkg::DEF_FRAME_LINES - 16'h0001, "read row");
    check(srow, SHUT_HOLD, "shutter row not held");
    check(first_lv >= 255 && first_lv < 280, 1'b1,
      "active before vblank");
    tick(40);
    check(fstart, 1'b0, "frame without pulse");
    check(armed, 1'b1, "lost armed state");
    fire = 1'b1;
    tick(1);
    fire = 1'b0;
    wait_start(w);
    check(w <= 6, 1'b1, "rearmed edge not taken");
    stream_en = 1'b0;
    trig_en = 1'b0;
    tick(4);
  endtask : t_slave
  task automatic t_free;
    int w, p0, p1, p2;
    slave_en = 1'b0;
    stream_en = 1'b1;
    wait_start(w);
    wait_start(p0);
    check(p0, FREE_CLKS, "free-run period");
    tick(100);
    cfg.extra_delay = 16'h0028;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    wait_start(w);
    wait_start(p1);
    wait_start(p2);
    check(p1, p0, "setting applied one frame early");
    check(p2 - p0, 40, "extra delay not applied at n+2");
    cfg = sfts_pkg::CFG_RESET;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
  endtask : t_free
  task automatic t_proto;
    logic [4:0] exp [4] = '{5'h00, 5'h14, 5'h1c, 5'h0f};
    logic [4:0] acc;
    logic lv_seen;
    logic fv_seen;
    int w;
    for (int p = 0; p < 4; p++) begin
      stream_en = 1'b0;
      proto = sfts_pkg::sfts_proto_t'(p[1:0]);
      tick(4);
      stream_en = 1'b1;
      wait_start(w);
      acc = 5'h00;
      lv_seen = 1'b0;
      fv_seen = 1'b0;
      repeat (620) begin
        @(negedge clk);
        acc = acc | codes;
        lv_seen = lv_seen | lvalid;
        fv_seen = fv_seen | fvalid;
      end
      check(acc, exp[p], "sync code set for protocol");
      check(lv_seen, 1'b1, "line valid never seen");
      check(fv_seen, 1'b1, "frame valid never seen");
    end
  endtask : t_proto
  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    tick(8);
    rst_n = 1'b1;
    tick(2);
    t_slave();
    t_free();
    t_proto();
    wrap_up();
  end
  // whole run is about 5200 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : slave_frame_trigger_sync_bench
`default_nettype wire
